// ==== pkg/plps_pkg.sv ====
// plps_pkg: register map, bit layouts and reset values of the port block
package plps_pkg;

  localparam logic [15:0] PLPS_ADDR_P1_DATA  = 16'hff01;
  localparam logic [15:0] PLPS_ADDR_P2_DATA  = 16'hff02;
  localparam logic [15:0] PLPS_ADDR_P3_DATA  = 16'hff03;
  localparam logic [15:0] PLPS_ADDR_P4_DATA  = 16'hff04;
  localparam logic [15:0] PLPS_ADDR_P10_DATA = 16'hff0a;
  localparam logic [15:0] PLPS_ADDR_P11_DATA = 16'hff0b;
  localparam logic [15:0] PLPS_ADDR_P12_DATA = 16'hff0c;
  localparam logic [15:0] PLPS_ADDR_P14_DATA = 16'hff0e;
  localparam logic [15:0] PLPS_ADDR_P15_DATA = 16'hff0f;
  localparam logic [15:0] PLPS_ADDR_P1_PU    = 16'hff31;
  localparam logic [15:0] PLPS_ADDR_P3_PU    = 16'hff33;
  localparam logic [15:0] PLPS_ADDR_P4_PU    = 16'hff34;
  localparam logic [15:0] PLPS_ADDR_P10_PU   = 16'hff3a;
  localparam logic [15:0] PLPS_ADDR_P11_PU   = 16'hff3b;
  localparam logic [15:0] PLPS_ADDR_P12_PU   = 16'hff3c;
  localparam logic [15:0] PLPS_ADDR_P14_PU   = 16'hff3e;
  localparam logic [15:0] PLPS_ADDR_P15_PU   = 16'hff3f;

  // implemented bits of each data latch, plus the read-only bits of port 12
  localparam logic [7:0] PLPS_MASK_P1_DATA  = 8'h0c;
  localparam logic [7:0] PLPS_MASK_P2_DATA  = 8'h3f;
  localparam logic [7:0] PLPS_MASK_P3_DATA  = 8'h1e;
  localparam logic [7:0] PLPS_MASK_P4_DATA  = 8'h01;
  localparam logic [7:0] PLPS_MASK_P10_DATA = 8'h03;
  localparam logic [7:0] PLPS_MASK_P11_DATA = 8'h0c;
  localparam logic [7:0] PLPS_MASK_P12_DATA = 8'h01;
  localparam logic [7:0] PLPS_MASK_P12_RO   = 8'h1e;
  localparam logic [7:0] PLPS_MASK_P14_DATA = 8'h0f;
  localparam logic [7:0] PLPS_MASK_P15_DATA = 8'h0f;
  // implemented bits of each pull-up enable
  localparam logic [7:0] PLPS_MASK_P1_PU    = 8'h0c;
  localparam logic [7:0] PLPS_MASK_P3_PU    = 8'h1e;
  localparam logic [7:0] PLPS_MASK_P4_PU    = 8'h01;
  localparam logic [7:0] PLPS_MASK_P10_PU   = 8'h03;
  localparam logic [7:0] PLPS_MASK_P11_PU   = 8'h0c;
  localparam logic [7:0] PLPS_MASK_P12_PU   = 8'h01;
  localparam logic [7:0] PLPS_MASK_P14_PU   = 8'h0f;
  localparam logic [7:0] PLPS_MASK_P15_PU   = 8'h0f;

  localparam logic [7:0] PLPS_RST_DATA = 8'h00;
  localparam logic [7:0] PLPS_RST_PU   = 8'h00;

  localparam int PLPS_NPORT = 9;
  // port slots: 0=P1 1=P2 2=P3 3=P4 4=P10 5=P11 6=P12 7=P14 8=P15
  localparam int PLPS_SLOT_P12 = 6;

endpackage

// ==== verilog/plps_port_slot.sv ====
// plps_port_slot: one 8-bit port, its data latch and pull-up enable
`timescale 1ns/1ps
module plps_port_slot
  import plps_pkg::*;
#(
  parameter logic [7:0] DATA_MASK = 8'h00,
  parameter logic [7:0] PU_MASK   = 8'h00,
  parameter logic [7:0] RO_MASK   = 8'h00
)
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // register writes
  input  wire logic       i_data_wr,
  input  wire logic       i_pu_wr,
  input  wire logic       i_bit_op,
  input  wire logic [2:0] i_bit_sel,
  input  wire logic [7:0] i_wdata,
  // pin side
  input  wire logic [7:0] i_pin_sync,
  input  wire logic [7:0] i_out_mode,
  input  wire logic [7:0] i_alt_out,
  input  wire logic [7:0] i_clk_in_mode,
  // results
  output logic      [7:0] o_data_rd,
  output logic      [7:0] o_pu_rd,
  output logic      [7:0] o_pin_out,
  output logic      [7:0] o_pin_oe,
  output logic      [7:0] o_pullup_on
);

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] pu;
    logic [7:0] pout;
    logic [7:0] poe;
    logic [7:0] pull;
    logic [7:0] drd;
  } plps_slot_t;

  plps_slot_t st_reg;
  plps_slot_t st_next;

  // merge a bit or byte write into the old value, keeping absent bits zero
  function automatic logic [7:0] plps_merge(input logic [7:0] old_v,
                                            input logic [7:0] wv,
                                            input logic       bitop,
                                            input logic [2:0] sel,
                                            input logic [7:0] msk);
    logic [7:0] r;
    r = old_v;
    if (bitop)
      r[sel] = wv[0];
    else
      r = wv;
    return r & msk;
  endfunction

  always_comb
  begin
    st_next = st_reg;
    if (i_data_wr)
      st_next.latch = plps_merge(st_reg.latch, i_wdata, i_bit_op,
                                 i_bit_sel, DATA_MASK);
    if (i_pu_wr)
      st_next.pu = plps_merge(st_reg.pu, i_wdata, i_bit_op,
                              i_bit_sel, PU_MASK);
    st_next.pout = st_next.latch;
    st_next.poe  = i_out_mode & DATA_MASK;
    // pull-up only on input-mode pins, never on any driven output
    st_next.pull = st_next.pu & ~i_out_mode & ~i_alt_out;
    st_next.drd  = ((i_out_mode & st_next.latch) |
                    (~i_out_mode & i_pin_sync)) & DATA_MASK;
    st_next.drd  = st_next.drd | (i_pin_sync & RO_MASK & ~i_clk_in_mode);
    st_next.drd  = st_next.drd & ~(i_clk_in_mode & RO_MASK);
    if (i_sys_rst)
    begin
      st_next = '0;
      st_next.latch = PLPS_RST_DATA;
      st_next.pu    = PLPS_RST_PU;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    st_reg <= st_next;
  end

  assign o_data_rd   = st_reg.drd;
  assign o_pu_rd     = st_reg.pu;
  assign o_pin_out   = st_reg.pout;
  assign o_pin_oe    = st_reg.poe;
  assign o_pullup_on = st_reg.pull;

endmodule

// ==== verilog/plps_top.sv ====
// plps_top: port output latches, pull-up enables and CPU register access
// Contract
// - In output mode a stored 0 drives low, a stored 1 drives high.
// - Port 12 bits 1 to 4 are read-only; writes do nothing.
// - Pins in clock-input mode always read as 0; the code forces 0 only on port 12 bits 1 to 4.
// - Pull-up connects per bit only when enabled and pin is input.
// - Output or alternate-output pins never get a pull-up.
// - Pull-up enable 0 disconnects, 1 connects.
// - All pull-up enables clear to zero on reset.
// - Pull-up enables take bit and byte writes; bit write touches one bit.
// - Output latches clear on reset and hold until next write.
// - Input-mode read returns pin level, latch unchanged.
// - Output-mode read returns the latch value.
`timescale 1ns/1ps
module plps_top
  import plps_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // cpu memory access
  input  wire logic        i_cpu_wr,
  input  wire logic        i_cpu_rd,
  input  wire logic        i_cpu_bit_op,
  input  wire logic [2:0]  i_cpu_bit_sel,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [7:0]  i_cpu_wdata,
  output logic      [7:0]  o_cpu_rdata,
  output logic             o_cpu_hit,
  // pin configuration from the mode and function logic, slot-major
  input  wire logic [71:0] i_out_mode,
  input  wire logic [71:0] i_alt_out,
  input  wire logic [71:0] i_clk_in_mode,
  // pins
  input  wire logic [71:0] i_pin_in,
  output logic      [71:0] o_pin_out,
  output logic      [71:0] o_pin_oe,
  output logic      [71:0] o_pullup_on
);

  // implemented bits per slot; port 2 has no pull-up register
  localparam logic [7:0] DMASK [PLPS_NPORT] = '{
    PLPS_MASK_P1_DATA,
    PLPS_MASK_P2_DATA,
    PLPS_MASK_P3_DATA,
    PLPS_MASK_P4_DATA,
    PLPS_MASK_P10_DATA,
    PLPS_MASK_P11_DATA,
    PLPS_MASK_P12_DATA,
    PLPS_MASK_P14_DATA,
    PLPS_MASK_P15_DATA
  };
  localparam logic [7:0] PMASK [PLPS_NPORT] = '{
    PLPS_MASK_P1_PU,
    8'h00,
    PLPS_MASK_P3_PU,
    PLPS_MASK_P4_PU,
    PLPS_MASK_P10_PU,
    PLPS_MASK_P11_PU,
    PLPS_MASK_P12_PU,
    PLPS_MASK_P14_PU,
    PLPS_MASK_P15_PU
  };
  // port 12 bits 1 to 4 read their pins and keep no latch
  localparam logic [7:0] RMASK [PLPS_NPORT] = '{
    8'h00,
    8'h00,
    8'h00,
    8'h00,
    8'h00,
    8'h00,
    PLPS_MASK_P12_RO,
    8'h00,
    8'h00
  };

  typedef logic [7:0] plps_byte_arr_t [PLPS_NPORT];

  // one-hot slot of the data latch at an address, zero when unmapped
  function automatic logic [PLPS_NPORT-1:0] plps_data_hit(
    input logic [15:0] addr);
    logic [PLPS_NPORT-1:0] hit;
    hit = '0;
    case (addr)
      PLPS_ADDR_P1_DATA:  hit[0] = 1'b1;
      PLPS_ADDR_P2_DATA:  hit[1] = 1'b1;
      PLPS_ADDR_P3_DATA:  hit[2] = 1'b1;
      PLPS_ADDR_P4_DATA:  hit[3] = 1'b1;
      PLPS_ADDR_P10_DATA: hit[4] = 1'b1;
      PLPS_ADDR_P11_DATA: hit[5] = 1'b1;
      PLPS_ADDR_P12_DATA: hit[PLPS_SLOT_P12] = 1'b1;
      PLPS_ADDR_P14_DATA: hit[7] = 1'b1;
      PLPS_ADDR_P15_DATA: hit[8] = 1'b1;
      default:            hit = '0;
    endcase
    return hit;
  endfunction

  // port 2 has no pull-up register, so no address selects slot 1
  function automatic logic [PLPS_NPORT-1:0] plps_pu_hit(
    input logic [15:0] addr);
    logic [PLPS_NPORT-1:0] hit;
    hit = '0;
    case (addr)
      PLPS_ADDR_P1_PU:  hit[0] = 1'b1;
      PLPS_ADDR_P3_PU:  hit[2] = 1'b1;
      PLPS_ADDR_P4_PU:  hit[3] = 1'b1;
      PLPS_ADDR_P10_PU: hit[4] = 1'b1;
      PLPS_ADDR_P11_PU: hit[5] = 1'b1;
      PLPS_ADDR_P12_PU: hit[PLPS_SLOT_P12] = 1'b1;
      PLPS_ADDR_P14_PU: hit[7] = 1'b1;
      PLPS_ADDR_P15_PU: hit[8] = 1'b1;
      default:          hit = '0;
    endcase
    return hit;
  endfunction

  // a strobe reaches only the slot that the address selects
  function automatic logic [PLPS_NPORT-1:0] plps_gate(
    input logic [PLPS_NPORT-1:0] sel,
    input logic                  en);
    return en ? sel : '0;
  endfunction

  // or-select one byte out of the slot values; selects are one-hot
  function automatic logic [7:0] plps_pick(
    input logic [PLPS_NPORT-1:0] sel,
    input plps_byte_arr_t        vals);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < PLPS_NPORT; k++)
    begin
      if (sel[k])
        r = r | vals[k];
    end
    return r;
  endfunction

  // sync1 may be metastable; nothing but sync2 reads it
  typedef struct packed {
    logic [71:0] sync1;
    logic [71:0] sync2;
    logic [7:0]  rdata;
    logic        hit;
  } plps_top_t;

  plps_top_t st_reg;
  plps_top_t st_next;

  logic [PLPS_NPORT-1:0] data_sel;
  logic [PLPS_NPORT-1:0] pu_sel;
  logic [PLPS_NPORT-1:0] data_wr;
  logic [PLPS_NPORT-1:0] pu_wr;
  plps_byte_arr_t        data_rd;
  plps_byte_arr_t        pu_rd;

  // one decode feeds both the write strobes and the read mux
  always_comb
  begin
    data_sel = plps_data_hit(i_cpu_addr);
    pu_sel   = plps_pu_hit(i_cpu_addr);
    data_wr  = plps_gate(data_sel, i_cpu_wr);
    pu_wr    = plps_gate(pu_sel, i_cpu_wr);
  end

  // bit writes merge into each slot's own latch, never the pin level
  genvar g;
  generate
    for (g = 0; g < PLPS_NPORT; g++)
    begin : g_slot
      plps_port_slot #(
        .DATA_MASK (DMASK[g]),
        .PU_MASK   (PMASK[g]),
        .RO_MASK   (RMASK[g])
      ) u_slot (
        .i_ref_clk     (i_ref_clk),
        .i_sys_rst     (i_sys_rst),
        .i_data_wr     (data_wr[g]),
        .i_pu_wr       (pu_wr[g]),
        .i_bit_op      (i_cpu_bit_op),
        .i_bit_sel     (i_cpu_bit_sel),
        .i_wdata       (i_cpu_wdata),
        .i_pin_sync    (st_reg.sync2[g*8 +: 8]),
        .i_out_mode    (i_out_mode[g*8 +: 8]),
        .i_alt_out     (i_alt_out[g*8 +: 8]),
        .i_clk_in_mode (i_clk_in_mode[g*8 +: 8]),
        .o_data_rd     (data_rd[g]),
        .o_pu_rd       (pu_rd[g]),
        .o_pin_out     (o_pin_out[g*8 +: 8]),
        .o_pin_oe      (o_pin_oe[g*8 +: 8]),
        .o_pullup_on   (o_pullup_on[g*8 +: 8])
      );
    end
  endgenerate

  // read data registered; unmapped addresses answer zero
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = i_pin_in;
    st_next.sync2 = st_reg.sync1;
    st_next.hit   = 1'b0;
    st_next.rdata = 8'h00;
    if (i_cpu_rd)
    begin
      // selects are one-hot, so or-ing both picks yields one register
      st_next.rdata = plps_pick(data_sel, data_rd) |
                      plps_pick(pu_sel, pu_rd);
      st_next.hit   = |{data_sel, pu_sel};
    end
    if (i_sys_rst)
      st_next = '0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    st_reg <= st_next;
  end

  // read answer stands for one cycle, then falls back to zero
  assign o_cpu_rdata = st_reg.rdata;
  assign o_cpu_hit   = st_reg.hit;

endmodule

// ==== verif/plps_properties.sv ====
// plps_properties: port-level assertions for the port latch block
`timescale 1ns/1ps
module plps_properties (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_cpu_wr,
  input wire logic        i_cpu_rd,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [71:0] i_out_mode,
  input wire logic [71:0] i_alt_out,
  input wire logic [7:0]  o_cpu_rdata,
  input wire logic        o_cpu_hit,
  input wire logic [71:0] o_pin_out,
  input wire logic [71:0] o_pin_oe,
  input wire logic [71:0] o_pullup_on
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // outputs are registered, so they answer last cycle's mode
  a_pu_off_out: assert property ((o_pullup_on & ($past(i_out_mode) |
    $past(i_alt_out))) == '0) else $error("pull-up on output pin");
  a_oe_mode: assert property ((o_pin_oe & ~$past(i_out_mode)) == '0)
    else $error("pin driven in input mode");
  a_bad_addr: assert property (i_cpu_rd && i_cpu_addr[15:8] != 8'hff
    |=> o_cpu_rdata == 8'h00 && !o_cpu_hit) else $error("unmapped read");
  a_hit_rd: assert property (o_cpu_hit |-> $past(i_cpu_rd))
    else $error("hit without read");
  a_rd_idle: assert property (!$past(i_cpu_rd) |->
    o_cpu_rdata == 8'h00) else $error("read data outside read");
  a_rst_clear: assert property ($past(i_sys_rst) |-> o_pin_out == '0
    && o_pullup_on == '0) else $error("outputs not cleared");
  a_latch_hold: assert property (!$past(i_cpu_wr) && !$past(i_sys_rst)
    |-> $stable(o_pin_out)) else $error("latch changed without write");
  a_ro_undriven: assert property (o_pin_oe[63:60] == 4'h0
    && o_pin_oe[55:49] == 7'h00) else $error("unimplemented pin driven");
  c_hit: cover property (o_cpu_hit);
  c_pullup: cover property (|o_pullup_on);
  c_drive: cover property (|o_pin_oe);
endmodule
bind plps_top plps_properties u_props (.i_ref_clk, .i_sys_rst, .i_cpu_wr,
  .i_cpu_rd, .i_cpu_addr, .i_out_mode, .i_alt_out, .o_cpu_rdata, .o_cpu_hit,
  .o_pin_out, .o_pin_oe, .o_pullup_on);

// ==== verif/plps_board.sv ====
// plps_board: external pin levels seen by the port block
`timescale 1ns/1ps
module plps_board (
  input  wire logic        i_ref_clk,
  input  wire logic [71:0] i_drv,
  input  wire logic [71:0] i_drv_en,
  input  wire logic [71:0] i_pin_out,
  input  wire logic [71:0] i_pin_oe,
  input  wire logic [71:0] i_pullup_on,
  output logic      [71:0] o_pin
);
  logic [71:0] flt_reg = '0;
  // floating pins wander so a read cannot match by luck
  always @(posedge i_ref_clk) flt_reg <= ~flt_reg;
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_drv_en & i_drv)
               | (~i_pin_oe & ~i_drv_en & (i_pullup_on | flt_reg));
endmodule

// ==== verif/plps_top_tb_top.sv ====
// plps_top_tb_top: directed scenarios for the port latch block
`timescale 1ns/1ps
module plps_top_tb_top
  import plps_pkg::*;
;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, bop = 0, hit;
  logic [2:0]  sel = 0;
  logic [15:0] adr = 0;
  logic [7:0]  wd = 0, rdat;
  logic [71:0] om = 0, ao = 0, cm = 0, bd = 0, be = 0, pin, po, oe, pu;
  int          error_cnt = 0;
  int          checked = 0;

  always #5 clk = ~clk;
  plps_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_cpu_wr(wr),
    .i_cpu_rd(rd), .i_cpu_bit_op(bop), .i_cpu_bit_sel(sel), .i_cpu_addr(adr),
    .i_cpu_wdata(wd), .o_cpu_rdata(rdat), .o_cpu_hit(hit), .i_out_mode(om),
    .i_alt_out(ao), .i_clk_in_mode(cm), .i_pin_in(pin), .o_pin_out(po),
    .o_pin_oe(oe), .o_pullup_on(pu));
  plps_board board (.i_ref_clk(clk), .i_drv(bd), .i_drv_en(be),
    .i_pin_out(po), .i_pin_oe(oe), .i_pullup_on(pu), .o_pin(pin));

  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task wrr(input logic [15:0] a, input logic [7:0] d, input logic b = 0,
           input logic [2:0] s = 0);
    @(posedge clk) #1;
    {wr, adr, wd, bop, sel} = {1'b1, a, d, b, s};
    @(posedge clk) #1;
    wr = 0;
  endtask
  task rdc(input logic [15:0] a, input logic [7:0] e, input logic h = 1);
    @(posedge clk) #1;
    {rd, adr} = {1'b1, a};
    @(posedge clk) #1;
    rd = 0;
    chk("rdata", e, rdat);
    chk("hit", {7'h00, h}, {7'h00, hit});
  endtask
  // pins pass a two-stage synchroniser, the slot register and the read register
  task settle;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task pu1(input logic [15:0] a, input logic [7:0] m, input int s);
    rdc(a, PLPS_RST_PU);
    wrr(a, 8'hff);
    rdc(a, m);
    chk("pullup", m, pu[8*s+:8]);
  endtask
  task t_pu;
    pu1(PLPS_ADDR_P1_PU, PLPS_MASK_P1_PU, 0);
    pu1(PLPS_ADDR_P3_PU, PLPS_MASK_P3_PU, 2);
    pu1(PLPS_ADDR_P4_PU, PLPS_MASK_P4_PU, 3);
    pu1(PLPS_ADDR_P10_PU, PLPS_MASK_P10_PU, 4);
    pu1(PLPS_ADDR_P11_PU, PLPS_MASK_P11_PU, 5);
    pu1(PLPS_ADDR_P12_PU, PLPS_MASK_P12_PU, 6);
    pu1(PLPS_ADDR_P14_PU, PLPS_MASK_P14_PU, 7);
    pu1(PLPS_ADDR_P15_PU, PLPS_MASK_P15_PU, 8);
    om = '1;
    settle;
    chk("pullup out", 8'h00, {7'h00, |pu});
    {om, ao} = {72'h0, {72{1'b1}}};
    settle;
    chk("pullup alt", 8'h00, {7'h00, |pu});
    ao = '0;
    wrr(PLPS_ADDR_P14_PU, 8'h00, 1, 3'h2);
    wrr(PLPS_ADDR_P14_PU, 8'h01, 1, 3'h7);
    rdc(PLPS_ADDR_P14_PU, 8'h0b);
    chk("pullup bit", 8'h0b, pu[63:56]);
  endtask
  task t_out;
    om[7:0] = 8'hff;
    wrr(PLPS_ADDR_P1_DATA, 8'hff);
    wrr(PLPS_ADDR_P1_DATA, 8'h04);
    settle;
    chk("pin out", 8'h04, po[7:0]);
    chk("pin oe", 8'h0c, oe[7:0]);
    rdc(PLPS_ADDR_P1_DATA, 8'h04);
    {om[7:0], be[7:0], bd[7:0]} = 24'h00_ff08;
    settle;
    rdc(PLPS_ADDR_P1_DATA, 8'h08);
    {om[7:0], be[7:0]} = 16'hff00;
    settle;
    rdc(PLPS_ADDR_P1_DATA, 8'h04);
  endtask
  task t_p12;
    {be[55:48], bd[55:48]} = 16'hffff;
    wrr(PLPS_ADDR_P12_DATA, 8'hfe);
    settle;
    rdc(PLPS_ADDR_P12_DATA, 8'h1f);
    cm[55:48] = 8'h1e;
    settle;
    rdc(PLPS_ADDR_P12_DATA, 8'h01);
    {be[48], om[48]} = 2'b01;
    settle;
    rdc(PLPS_ADDR_P12_DATA, 8'h00);
  endtask
  task t_misc;
    wrr(16'hff05, 8'hff);
    rdc(16'hff05, 8'h00, 0);
    rdc(16'h0f01, 8'h00, 0);
    rst = 1;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
    chk("latch rst", 8'h00, {7'h00, |po});
    chk("pullup rst", 8'h00, {7'h00, |pu});
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    t_pu;
    t_out;
    t_p12;
    t_misc;
    end_of_test;
  end
endmodule
